// ### verilog/dsp_pkg.sv
// Purpose: Shared constants and types for the cable port data path
// Assumes: clk_i stands in for the PLL output; link clock is a divide by eight
// Notes:   Speed code 0/1/2 selects low, mid and high grade
package dsp_pkg;
    // Clock plan in kHz; bit rates in kbit/s, CLK_HZ in Hz
    localparam int PLL_KHZ      = 393216;
    localparam int LINK_KHZ     = 49152;
    localparam int LOW_KBPS     = 98304;
    localparam int MID_KBPS     = 196608;
    localparam int HIGH_KBPS    = 393216;
    localparam int CLK_HZ       = 10000000;
    localparam int LINK_DIV     = PLL_KHZ / LINK_KHZ;
    localparam int PHASE_W      = 3;
    localparam logic [PHASE_W-1:0] PHASE_RST  = 3'h0;
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(LINK_DIV - 1);
    localparam logic [PHASE_W-1:0] PHASE_HALF = PHASE_W'(LINK_DIV / 2);
    // Bit periods in fast clock cycles
    localparam logic [2:0] PER_LOW  = 3'(PLL_KHZ / LOW_KBPS);
    localparam logic [2:0] PER_MID  = 3'(PLL_KHZ / MID_KBPS);
    localparam logic [2:0] PER_HIGH = 3'(PLL_KHZ / HIGH_KBPS);
    localparam int WORD_W        = 8;
    localparam int ENTRY_W       = WORD_W + 2;
    localparam int TX_FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        SPD_LOW  = 2'h0,
        SPD_MID  = 2'h1,
        SPD_HIGH = 2'h2
    } dsp_speed_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } dsp_tx_state_e;
endpackage

// ### verilog/dsp_fifo_if.sv
// Purpose: Valid/ready carrier between the data path and its FIFO
// Assumes: One clock domain
// Notes:   Data is carried whole, no byte lanes
`timescale 1ns/1ps
interface dsp_fifo_if #(parameter int WIDTH = 10);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport fifo (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
    modport user (output wr_valid, output wr_data, output rd_ready,
                  input wr_ready, input rd_valid, input rd_data);
endinterface

// ### verilog/dsp_fifo.sv
// Purpose: Outbound word FIFO
// Assumes: DEPTH a power of two
// Notes:   Read data is combinational from the array
`timescale 1ns/1ps
module dsp_fifo
    import dsp_pkg::*;
#(
    parameter int WIDTH = ENTRY_W,
    parameter int DEPTH = TX_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    dsp_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);

    if ((DEPTH < 2) || ((1 << PW) != DEPTH) || (WIDTH != $bits(f.wr_data))) begin : g_chk
        $error("dsp_fifo: depth must be a power of two and width must match");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      cnt_reg;
    logic [PW:0]      cnt_next;
    logic             push;
    logic             pop;

    assign f.wr_ready = (cnt_reg != (PW+1)'(DEPTH));
    assign f.rd_valid = (cnt_reg != '0);
    assign f.rd_data  = mem[rd_ptr_reg];
    assign push       = f.wr_valid && f.wr_ready;
    assign pop        = f.rd_ready && f.rd_valid;

    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= f.wr_data;
        end
    end

    property p_fifo_bound;
        @(posedge clk_i) disable iff (!reset_n_i)
        (cnt_reg == (PW+1)'(DEPTH)) |=> (cnt_reg <= (PW+1)'(DEPTH));
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo count ran past depth");
endmodule // dsp_fifo

// ### verilog/dsp_port_datapath.sv
// Purpose: Cable port data path: serialise, encode, decode, regroup
// Assumes: Link controller runs on link_side_clock_o; arbitration is outside
// Notes:   clk_i models the fast bit clock; link clock is one eighth of it
`timescale 1ns/1ps
module dsp_port_datapath
    import dsp_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       power_down_input_i,
    input  wire logic       iso_n_i,
    input  wire logic       port_off_i,
    input  wire logic       rx_active_i,
    input  wire logic [1:0] rx_speed_i,
    input  wire logic       tx_valid_i,
    input  wire logic [1:0] tx_speed_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            link_side_clock_o,
    output logic            pll_run_o,
    output logic            bias_detect_en_o,
    output logic            rx_en_o,
    input  wire logic       cable_pair_a_i,
    output logic            cable_pair_a_o,
    output logic            cable_pair_a_oe_o,
    input  wire logic       cable_pair_b_i,
    output logic            cable_pair_b_o,
    output logic            cable_pair_b_oe_o
);
    if (LINK_DIV != (1 << PHASE_W)) begin : g_chk
        $error("dsp_port_datapath: link divider must equal phase counter range");
    end

    function automatic logic [3:0] word_bits(input logic [1:0] spd);
        case (spd)
            SPD_LOW: word_bits = 4'h2;
            SPD_MID: word_bits = 4'h4;
            default: word_bits = 4'h8;
        endcase
    endfunction

    function automatic logic [2:0] bit_period(input logic [1:0] spd);
        case (spd)
            SPD_LOW: bit_period = PER_LOW;
            SPD_MID: bit_period = PER_MID;
            default: bit_period = PER_HIGH;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic pwr_s1_reg, pwr_s2_reg, iso_s1_reg, iso_s2_reg;
    logic pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg;
    logic pwr_s1_next, pwr_s2_next, iso_s1_next, iso_s2_next;
    logic pa_s1_next, pa_s2_next, pb_s1_next, pb_s2_next;
    logic rst_int;

    always_comb begin
        pwr_s1_next = power_down_input_i;
        pwr_s2_next = pwr_s1_reg;
        iso_s1_next = iso_n_i;
        iso_s2_next = iso_s1_reg;
        pa_s1_next  = cable_pair_a_i;
        pa_s2_next  = pa_s1_reg;
        pb_s1_next  = cable_pair_b_i;
        pb_s2_next  = pb_s1_reg;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pwr_s1_reg <= 1'b0;
            pwr_s2_reg <= 1'b0;
            iso_s1_reg <= 1'b1;
            iso_s2_reg <= 1'b1;
            pa_s1_reg  <= 1'b0;
            pa_s2_reg  <= 1'b0;
            pb_s1_reg  <= 1'b0;
            pb_s2_reg  <= 1'b0;
        end else begin
            pwr_s1_reg <= pwr_s1_next;
            pwr_s2_reg <= pwr_s2_next;
            iso_s1_reg <= iso_s1_next;
            iso_s2_reg <= iso_s2_next;
            pa_s1_reg  <= pa_s1_next;
            pa_s2_reg  <= pa_s2_next;
            pb_s1_reg  <= pb_s1_next;
            pb_s2_reg  <= pb_s2_next;
        end
    end

    // Power down holds the logic in reset, as the reset pin does
    assign rst_int = !reset_n_i || pwr_s2_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Link-side clock divider
    logic [PHASE_W-1:0] phase_reg, phase_next;
    logic               lclk_next, pll_next, bias_next;

    always_comb begin
        phase_next = (phase_reg == PHASE_LAST) ? PHASE_RST : phase_reg + 3'h1;
        // Low in the capture cycle, so the capture edge is the link clock's rise
        lclk_next  = (phase_next != PHASE_RST) && (phase_next <= PHASE_HALF);
        pll_next   = 1'b1;
        bias_next  = 1'b1;
        if (rst_int) begin
            phase_next = PHASE_RST;
            lclk_next  = 1'b0;
            pll_next   = !pwr_s2_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        phase_reg         <= phase_next;
        link_side_clock_o <= lclk_next;
        pll_run_o         <= pll_next;
        bias_detect_en_o  <= bias_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit: capture into FIFO, serialise, data-strobe encode
    dsp_fifo_if #(.WIDTH(ENTRY_W)) fif ();

    dsp_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i     (clk_i),
        .reset_n_i (!rst_int),
        .f         (fif.fifo)
    );

    // Capture only on the link clock's rising phase
    assign fif.wr_valid = tx_valid_i && tx_ready_o && (phase_reg == PHASE_RST);
    assign fif.wr_data  = {tx_speed_i, tx_data_i};

    dsp_tx_state_e tx_st_reg, tx_st_next;
    logic [7:0]    tx_sh_reg, tx_sh_next;
    logic [3:0]    tx_left_reg, tx_left_next;
    logic [2:0]    tx_per_reg, tx_per_next;
    logic [1:0]    tx_spd_reg, tx_spd_next;
    logic          d_next, s_next, oe_next, rdy_next;
    logic          can_tx, start, start_bit, pop;
    logic [3:0]    ld_n;

    // Reception owns the port; no transmit while it is busy or the port is off
    assign can_tx = !rx_active_i && !port_off_i;
    assign ld_n   = word_bits(fif.rd_data[9:8]);
    assign fif.rd_ready = pop;

    always_comb begin
        tx_st_next   = tx_st_reg;
        tx_sh_next   = tx_sh_reg;
        tx_left_next = tx_left_reg;
        tx_per_next  = tx_per_reg;
        tx_spd_next  = tx_spd_reg;
        pop          = 1'b0;
        start        = 1'b0;
        start_bit    = 1'b0;
        case (tx_st_reg)
            TX_IDLE: begin
                if (can_tx && fif.rd_valid) begin
                    pop = 1'b1;
                end
            end
            TX_SEND: begin
                if (!can_tx) begin
                    tx_st_next = TX_IDLE;
                end else if (tx_per_reg != 3'h0) begin
                    tx_per_next = tx_per_reg - 3'h1;
                end else if (tx_left_reg != 4'h1) begin
                    tx_sh_next   = {tx_sh_reg[6:0], 1'b0};
                    tx_left_next = tx_left_reg - 4'h1;
                    tx_per_next  = bit_period(tx_spd_reg) - 3'h1;
                    start        = 1'b1;
                    start_bit    = tx_sh_reg[6];
                end else if (fif.rd_valid) begin
                    pop = 1'b1;
                end else begin
                    tx_st_next = TX_IDLE;
                end
            end
            default: tx_st_next = TX_IDLE;
        endcase
        if (pop) begin
            // Lanes sit low; left-align so bit 7 always goes first
            tx_sh_next   = fif.rd_data[7:0] << (4'h8 - ld_n);
            tx_left_next = ld_n;
            tx_spd_next  = fif.rd_data[9:8];
            tx_per_next  = bit_period(fif.rd_data[9:8]) - 3'h1;
            tx_st_next   = TX_SEND;
            start        = 1'b1;
            start_bit    = tx_sh_next[7];
        end
        // Strobe toggles only when data repeats
        d_next = start ? start_bit : cable_pair_b_o;
        s_next = (start && (start_bit == cable_pair_b_o)) ? !cable_pair_a_o
                                                           : cable_pair_a_o;
        oe_next  = (tx_st_next == TX_SEND);
        rdy_next = fif.wr_ready;
        if (rst_int) begin
            tx_st_next   = TX_IDLE;
            tx_sh_next   = 8'h00;
            tx_left_next = 4'h0;
            tx_per_next  = 3'h0;
            tx_spd_next  = SPD_LOW;
            d_next       = 1'b0;
            s_next       = 1'b0;
            oe_next      = 1'b0;
            rdy_next     = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        tx_st_reg         <= tx_st_next;
        tx_sh_reg         <= tx_sh_next;
        tx_left_reg       <= tx_left_next;
        tx_per_reg        <= tx_per_next;
        tx_spd_reg        <= tx_spd_next;
        cable_pair_b_o    <= d_next;
        cable_pair_a_o    <= s_next;
        cable_pair_a_oe_o <= oe_next;
        cable_pair_b_oe_o <= oe_next;
        tx_ready_o        <= rdy_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive: decode, regroup, hand over on the link clock
    logic       rx_on, rx_evt;
    logic       pa_prev_reg, pb_prev_reg, pa_prev_next, pb_prev_next;
    logic [7:0] rx_sh_reg, rx_sh_next, hold_reg, hold_next, rdata_next;
    logic [3:0] rx_cnt_reg, rx_cnt_next;
    logic       hv_reg, hv_next, rvalid_next, rxen_next;

    assign rx_on  = rx_active_i && !port_off_i;
    // Data on pair A, strobe on pair B; any change of their XOR is a bit
    assign rx_evt = rx_on && ((pa_s2_reg ^ pb_s2_reg) != (pa_prev_reg ^ pb_prev_reg));

    always_comb begin
        pa_prev_next = pa_s2_reg;
        pb_prev_next = pb_s2_reg;
        rx_sh_next   = rx_sh_reg;
        rx_cnt_next  = rx_cnt_reg;
        hold_next    = hold_reg;
        hv_next      = hv_reg;
        rdata_next   = rx_data_o;
        rvalid_next  = 1'b0;
        rxen_next    = rx_on;
        if (phase_reg == PHASE_RST) begin
            rvalid_next = hv_reg;
            hv_next     = 1'b0;
            if (hv_reg) begin
                // Low isolation select sends changes only, for a coupling barrier
                rdata_next = iso_s2_reg ? hold_reg : (rx_data_o ^ hold_reg);
            end
        end
        if (!rx_on) begin
            rx_cnt_next = 4'h0;
        end else if (rx_evt) begin
            rx_sh_next = {rx_sh_reg[6:0], pa_s2_reg};
            if (rx_cnt_reg + 4'h1 == word_bits(rx_speed_i)) begin
                hold_next   = {rx_sh_reg[6:0], pa_s2_reg};
                hv_next     = 1'b1; // Set wins over the hand-over clear
                rx_cnt_next = 4'h0;
            end else begin
                rx_cnt_next = rx_cnt_reg + 4'h1;
            end
        end
        if (rst_int) begin
            pa_prev_next = 1'b0;
            pb_prev_next = 1'b0;
            rx_sh_next   = 8'h00;
            rx_cnt_next  = 4'h0;
            hold_next    = 8'h00;
            hv_next      = 1'b0;
            rdata_next   = 8'h00;
            rvalid_next  = 1'b0;
            rxen_next    = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        pa_prev_reg <= pa_prev_next;
        pb_prev_reg <= pb_prev_next;
        rx_sh_reg   <= rx_sh_next;
        rx_cnt_reg  <= rx_cnt_next;
        hold_reg    <= hold_next;
        hv_reg      <= hv_next;
        rx_data_o   <= rdata_next;
        rx_valid_o  <= rvalid_next;
        rx_en_o     <= rxen_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_int);

    sequence s_word_gap;
        !pop [*7];
    endsequence

    sequence s_lclk_high;
        link_side_clock_o [*4] ##1 !link_side_clock_o;
    endsequence

    property p_capture_phase;
        fif.wr_valid |-> (phase_reg == PHASE_RST) && link_side_clock_o == 1'b0;
    endproperty
    a_capture_phase: assert property (p_capture_phase)
        else $error("outbound word taken off the link clock edge");

    property p_lclk_shape;
        $rose(link_side_clock_o) |-> s_lclk_high;
    endproperty
    a_lclk_shape: assert property (p_lclk_shape)
        else $error("link clock high time is not four cycles");

    property p_word_time;
        pop |=> s_word_gap;
    endproperty
    a_word_time: assert property (p_word_time)
        else $error("outbound word shorter than one link clock period");

    property p_ds_code;
        cable_pair_a_oe_o && $past(cable_pair_a_oe_o) |->
            !((cable_pair_a_o != $past(cable_pair_a_o)) &&
              (cable_pair_b_o != $past(cable_pair_b_o)));
    endproperty
    a_ds_code: assert property (p_ds_code)
        else $error("data and strobe changed together");

    property p_rx_drv_off;
        rx_active_i |=> !cable_pair_a_oe_o && !cable_pair_b_oe_o;
    endproperty
    a_rx_drv_off: assert property (p_rx_drv_off)
        else $error("driver on during reception");

    property p_port_off;
        port_off_i |=> !rx_en_o && !cable_pair_b_oe_o && !cable_pair_a_oe_o;
    endproperty
    a_port_off: assert property (p_port_off)
        else $error("port circuitry on while port is off");

    property p_rx_valid;
        rx_valid_o |-> (phase_reg == 3'h1) ##1 !rx_valid_o;
    endproperty
    a_rx_valid: assert property (p_rx_valid)
        else $error("receive word not aligned to the link clock");

    property p_rx_bit;
        rx_evt |=> rx_sh_reg[0] == $past(pa_s2_reg);
    endproperty
    a_rx_bit: assert property (p_rx_bit)
        else $error("received bit not taken from pair A");

    property p_pwrdn_off;
        @(posedge clk_i) disable iff (!reset_n_i)
        pwr_s2_reg |=> !pll_run_o && !rx_en_o && !cable_pair_b_oe_o && bias_detect_en_o;
    endproperty
    a_pwrdn_off: assert property (p_pwrdn_off)
        else $error("circuits still on in power down");
endmodule // dsp_port_datapath

// ### test/dsp_cable_partner.sv
// Purpose: Remote cable end that sends and reads data-strobe words
// Assumes: Bit period is given in fast clock cycles
// Notes:   Idle receive data toggles so a stale level never looks valid
`timescale 1ns/1ps
module dsp_cable_partner (
    input  wire logic clk_i,
    input  wire logic hush_i,
    input  wire logic data_i,
    input  wire logic strobe_i,
    input  wire logic drive_i,
    output logic      data_o,
    output logic      strobe_o
);
    int   ds_bad = 0;
    logic dprev;
    logic sprev;
    logic was;
    initial begin
        data_o = 1'b0;
        strobe_o = 1'b0;
        was = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Released line changes every cycle
    always @(negedge clk_i) begin
        if (!hush_i) data_o = ~data_o;
        if (drive_i && was && data_i !== dprev && strobe_i !== sprev) ds_bad++;
        dprev = data_i;
        sprev = strobe_i;
        was = drive_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic send_rx(input logic [7:0] w, input int n, input int per);
        for (int k = n - 1; k >= 0; k--) begin
            if (w[k] !== data_o) data_o = w[k];
            else strobe_o = ~strobe_o;
            repeat (per) @(negedge clk_i);
        end
    endtask

    task automatic get_tx(input int per, input int n, output logic [15:0] w, output bit ok);
        int   t;
        logic px;
        w = '0;
        t = 0;
        while (drive_i !== 1'b1 && t < 400) begin
            @(negedge clk_i);
            t++;
        end
        ok = (t < 400);
        for (int k = 0; k < n; k++) begin
            if (k > 0 && (data_i ^ strobe_i) === px) ds_bad++;
            px = data_i ^ strobe_i;
            w = {w[14:0], data_i};
            repeat (per) @(negedge clk_i);
        end
    endtask
endmodule // dsp_cable_partner

// ### test/ds_cable_port_datapath_test.sv
// Purpose: Self-checking bench for the cable port data path
// Assumes: Inputs change on the falling edge
// Notes:   Cable traffic comes from the partner model
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module ds_cable_port_datapath_test;
    import dsp_pkg::*;
    typedef struct packed {logic rx; dsp_speed_e s; logic [7:0] w;} dsp_row_s;
    logic       clk_i = 0, reset_n_i = 0, power_down_input_i = 0, iso_n_i = 1;
    logic       port_off_i = 0, rx_active_i = 0, tx_valid_i = 0, hush = 0;
    logic [1:0] rx_speed_i = 0, tx_speed_i = 0;
    logic [7:0] tx_data_i = 0, rx_data_o, m, lk;
    logic       tx_ready_o, rx_valid_o, link_side_clock_o, pll_run_o, bias_detect_en_o;
    logic       rx_en_o, cable_pair_a_i, cable_pair_a_o, cable_pair_a_oe_o;
    logic       cable_pair_b_i, cable_pair_b_o, cable_pair_b_oe_o;
    logic [15:0] got;
    int         bad_count = 0, check_count = 0;
    dsp_row_s   rows [6] = '{'{1'b0, SPD_LOW, 8'h02}, '{1'b0, SPD_MID, 8'h0b},
        '{1'b0, SPD_HIGH, 8'ha5}, '{1'b1, SPD_LOW, 8'h01}, '{1'b1, SPD_MID, 8'h06},
        '{1'b1, SPD_HIGH, 8'h3c}};

    dsp_port_datapath DUT (.clk_i, .reset_n_i, .power_down_input_i, .iso_n_i, .port_off_i,
        .rx_active_i, .rx_speed_i, .tx_valid_i, .tx_speed_i, .tx_data_i, .tx_ready_o,
        .rx_data_o, .rx_valid_o, .link_side_clock_o, .pll_run_o, .bias_detect_en_o, .rx_en_o,
        .cable_pair_a_i, .cable_pair_a_o, .cable_pair_a_oe_o, .cable_pair_b_i,
        .cable_pair_b_o, .cable_pair_b_oe_o);
    dsp_cable_partner cp (.clk_i, .hush_i(hush), .data_i(cable_pair_b_o),
        .strobe_i(cable_pair_a_o), .drive_i(cable_pair_b_oe_o), .data_o(cable_pair_a_i),
        .strobe_o(cable_pair_b_i));
    ////////////////////////////////////////////////////////////////////////
    // Clock runs before reset is released
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        int t;
        t = 0;
        while (s !== v) begin
            @(negedge clk_i);
            t++;
            if (t > lim) begin
                bad_count++;
                end_of_test();
            end
        end
    endtask

    function automatic int per_of(dsp_speed_e s);
        return s == SPD_LOW ? int'(PER_LOW) : s == SPD_MID ? int'(PER_MID) : int'(PER_HIGH);
    endfunction

    // Window of one link period from a rise always holds one capture edge
    task automatic send_tx(input logic [15:0] w, input int nw, input dsp_speed_e s);
        wait_for(link_side_clock_o, 1'b0, 20);
        wait_for(link_side_clock_o, 1'b1, 20);
        for (int i = 0; i < nw; i++) begin
            tx_valid_i = 1'b1;
            tx_speed_i = s;
            tx_data_i = w[8*i +: 8];
            repeat (8) @(negedge clk_i);
        end
        tx_valid_i = 1'b0;
    endtask

    task automatic do_tx(input logic [15:0] w, input int nw, input dsp_speed_e s);
        bit ok;
        fork
            send_tx(w, nw, s);
            cp.get_tx(per_of(s), nw * 8 / per_of(s), got, ok);
        join
        if (!ok) begin
            bad_count++;
            end_of_test();
        end
    endtask

    // Noise stops early so no edge is left in the sync chain
    task automatic do_rx(input logic [7:0] w, input dsp_speed_e s);
        hush = 1'b1;
        rx_speed_i = s;
        repeat (4) @(negedge clk_i);
        rx_active_i = 1'b1;
        repeat (4) @(negedge clk_i);
        cp.send_rx(w, 8 / per_of(s), per_of(s));
        wait_for(rx_valid_o, 1'b1, 40);
        rx_active_i = 1'b0;
        hush = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk_i);
        reset_n_i = 1'b1;
        foreach (rows[i]) begin
            m = 8'hff >> (8 - 8 / per_of(rows[i].s));
            if (rows[i].rx) begin
                do_rx(rows[i].w, rows[i].s);
                `CHK(rx_data_o & m, rows[i].w)
            end else begin
                do_tx({8'h00, rows[i].w}, 1, rows[i].s);
                `CHK(got[7:0] & m, rows[i].w)
            end
        end
        iso_n_i = 1'b0;
        do_rx(8'h99, SPD_HIGH);
        `CHK(rx_data_o, 8'h3c ^ 8'h99)
        iso_n_i = 1'b1;
        wait_for(link_side_clock_o, 1'b0, 20);
        wait_for(link_side_clock_o, 1'b1, 20);
        for (int i = 0; i < 8; i++) begin
            lk = {lk[6:0], link_side_clock_o};
            @(negedge clk_i);
        end
        `CHK(lk, 8'hf0)
        do_tx(16'h3cc5, 2, SPD_HIGH);
        `CHK(got, 16'hc53c)
        fork
            send_tx(16'h0003, 1, SPD_LOW);
            wait_for(cable_pair_b_oe_o, 1'b1, 40);
        join
        rx_active_i = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK({cable_pair_a_oe_o, cable_pair_b_oe_o, rx_en_o}, 3'h1)
        port_off_i = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK(rx_en_o, 1'b0)
        rx_active_i = 1'b0;
        repeat (18) send_tx(16'h00a5, 1, SPD_HIGH);
        `CHK({tx_ready_o, cable_pair_b_oe_o}, 2'h0)
        port_off_i = 1'b0;
        wait_for(cable_pair_b_oe_o, 1'b1, 40);
        wait_for(cable_pair_b_oe_o, 1'b0, 400);
        `CHK(tx_ready_o, 1'b1)
        power_down_input_i = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK({pll_run_o, bias_detect_en_o, cable_pair_b_oe_o, link_side_clock_o}, 4'h4)
        power_down_input_i = 1'b0;
        repeat (4) @(negedge clk_i);
        `CHK(pll_run_o, 1'b1)
        reset_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK({tx_ready_o, rx_valid_o, rx_data_o, link_side_clock_o, cable_pair_a_o, cable_pair_b_o, cable_pair_a_oe_o, cable_pair_b_oe_o, rx_en_o}, 16'h0)
        reset_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK({tx_ready_o, link_side_clock_o, cable_pair_b_oe_o}, 3'h6)
        `CHK(cp.ds_bad, 0)
        end_of_test();
    end
endmodule // ds_cable_port_datapath_test
